// *** src/shld_agu.sv ***
module shld_agu #(
    parameter int WIDTH = 32,
    parameter int ALIGN_BITS = 2
) (
    // Operands
    input wire logic [WIDTH-1:0] base_val_i,
    input wire logic [WIDTH-1:0] pc_i,
    input wire logic [WIDTH-1:0] off_val_i,
    input wire logic [WIDTH-1:0] imm32_i,
    input wire logic [1:0] shift_i,
    // Mode
    input wire logic use_reg_i,
    input wire logic lit_i,
    input wire logic add_i,
    input wire logic index_i,
    // Results
    output logic [WIDTH-1:0] offset_addr_o,
    output logic [WIDTH-1:0] access_addr_o
);
    wire [WIDTH-1:0] pc_aligned = {pc_i[WIDTH-1:ALIGN_BITS], {ALIGN_BITS{1'b0}}}; // RULE_11
    wire [WIDTH-1:0] base = lit_i ? pc_aligned : base_val_i;
    wire [WIDTH-1:0] offset = use_reg_i ? (off_val_i << shift_i) : imm32_i; // RULE_14

    // Subtraction when the add bit is clear; wraps modulo 2^WIDTH
    assign offset_addr_o = add_i ? base + offset : base - offset; // RULE_06
    assign access_addr_o = index_i ? offset_addr_o : base; // RULE_07
endmodule

// *** src/shld_decode.sv ***
module shld_decode
    import shld_pkg::*;
(
    // Instruction
    input wire logic [31:0] instr_i,
    input wire logic is32_i,
    // Decoded fields
    output shld_kind_t kind_o,
    output logic [3:0] dest_reg_field_o,
    output logic [3:0] base_reg_field_o,
    output logic [3:0] offset_reg_field_o,
    output logic [1:0] shift_2bit_o,
    output logic [31:0] imm32_o,
    output logic use_reg_o,
    output logic lit_o,
    output logic add_o,
    output logic index_o,
    output logic wback_o,
    output logic unpred_o
);
    wire [15:0] hw1 = instr_i[31:16];
    wire [15:0] hw2 = instr_i[15:0];
    wire [3:0] rt = hw2[15:12];
    wire [3:0] rn = hw1[3:0];
    wire p_bit = hw2[10];
    wire u_bit = hw2[9];
    wire w_bit = hw2[8];

    // Encoding class detection; literal has priority over every base form
    wire is_lit = is32_i && hw1[15:8] == SHLD_OP_LIT_HI && hw1[6:0] == SHLD_OP_LIT_LO; // RULE_01
    wire grp93 = is32_i && hw1[15:4] == SHLD_OP_GRP93 && !is_lit;
    wire is_offset_12bit = is32_i && hw1[15:4] == SHLD_OP_OFFSET_12BIT && !is_lit;
    wire is_offset_8bit = grp93 && hw2[11];
    wire is_regw = grp93 && hw2[11:6] == SHLD_REGW_ZERO;
    wire is_reg16 = !is32_i && instr_i[15:9] == SHLD_OP_REG16;
    wire is_load_word_unpriv = is32_i && hw1[15:4] == SHLD_OP_WORD_UNPRIV &&
        hw2[11:8] == SHLD_UNPRIV_SEL && rn != SHLD_REG_PC;
    wire rt_pc = rt == SHLD_REG_PC;
    wire rt_sp = rt == SHLD_REG_SP;

    // Sub-cases of the 8-bit indexed form
    wire i8_hint = is_offset_8bit && rt_pc && p_bit && !u_bit && !w_bit; // RULE_05
    wire i8_unpriv = is_offset_8bit && p_bit && u_bit && !w_bit && !i8_hint; // RULE_04
    wire i8_undef = is_offset_8bit && !p_bit && !w_bit; // RULE_03
    wire i8_norm = is_offset_8bit && !i8_hint && !i8_unpriv && !i8_undef;
    wire hint = ((is_lit || is_offset_12bit || is_regw) && rt_pc) || i8_hint; // RULE_13

    assign kind_o = hint ? SHLD_K_HINT :
        i8_undef ? SHLD_K_UNDEF :
        i8_unpriv ? SHLD_K_HALF_UNPRIV :
        (is_lit || is_offset_12bit || i8_norm || is_regw || is_reg16) ? SHLD_K_HALF :
        is_load_word_unpriv ? SHLD_K_WORD_UNPRIV : SHLD_K_NONE;

    // Register fields; the short encoding uses three-bit fields
    assign dest_reg_field_o = is_reg16 ? {1'b0, instr_i[2:0]} : rt;
    assign base_reg_field_o = is_reg16 ? {1'b0, instr_i[5:3]} : rn;
    assign offset_reg_field_o = is_reg16 ? {1'b0, instr_i[8:6]} : hw2[3:0];
    assign shift_2bit_o = is_regw ? hw2[5:4] : 2'b00; // RULE_14
    assign use_reg_o = is_regw || is_reg16;
    assign lit_o = is_lit;

    // Offsets are zero-extended from twelve or eight bits
    assign imm32_o = (is_lit || is_offset_12bit) ? {20'h00000, hw2[11:0]} :
        {24'h000000, hw2[7:0]}; // RULE_02 RULE_12 RULE_18

    // Addressing mode; only the plain 8-bit form varies them, apart from the literal form's add bit
    assign add_o = is_lit ? hw1[7] : (i8_norm ? u_bit : 1'b1); // RULE_06 RULE_12 RULE_15
    assign index_o = i8_norm ? p_bit : 1'b1; // RULE_07
    assign wback_o = i8_norm ? w_bit : 1'b0; // RULE_15 RULE_18

    // Unpredictable register choices per form
    assign unpred_o = ((is_lit || is_offset_12bit) && rt_sp) ||
        (i8_norm && (rt_sp || (rt_pc && w_bit) || (w_bit && rn == rt))) || // RULE_08
        (is_regw && (rt_sp || hw2[3:0] == SHLD_REG_SP || hw2[3:0] == SHLD_REG_PC)) || // RULE_16
        ((i8_unpriv || is_load_word_unpriv) && (rt_sp || rt_pc)); // RULE_18
endmodule

// *** src/shld_pkg.sv ***
package shld_pkg;

    // Opcode fields of the first halfword, upper twelve bits
    localparam logic [11:0] SHLD_OP_OFFSET_12BIT = 12'hf9b;
    localparam logic [11:0] SHLD_OP_GRP93 = 12'hf93;
    localparam logic [11:0] SHLD_OP_WORD_UNPRIV = 12'hf85;

    // Literal form: upper byte and low seven bits of the first halfword
    localparam logic [7:0] SHLD_OP_LIT_HI = 8'hf9;
    localparam logic [6:0] SHLD_OP_LIT_LO = 7'h3f;

    // Short register-offset encoding, bits 15:9
    localparam logic [6:0] SHLD_OP_REG16 = 7'h2f;

    // Second halfword selectors
    localparam logic [5:0] SHLD_REGW_ZERO = 6'h00;
    localparam logic [3:0] SHLD_UNPRIV_SEL = 4'he;

    // Register numbers with special meaning
    localparam logic [3:0] SHLD_REG_SP = 4'hd;
    localparam logic [3:0] SHLD_REG_PC = 4'hf;

    // Access sizes in bytes
    localparam logic [2:0] SHLD_SIZE_HALF = 3'h2;
    localparam logic [2:0] SHLD_SIZE_WORD = 3'h4;

    // Literal base is the program counter aligned down to four bytes
    localparam int SHLD_PC_ALIGN_BITS = 2;

    // What a decoded instruction turns out to be
    typedef enum {
        SHLD_K_NONE,
        SHLD_K_HINT,
        SHLD_K_UNDEF,
        SHLD_K_HALF,
        SHLD_K_HALF_UNPRIV,
        SHLD_K_WORD_UNPRIV
    } shld_kind_t;

    // Sequencer states
    typedef enum {
        SHLD_S_IDLE,
        SHLD_S_EXEC,
        SHLD_S_MEM,
        SHLD_S_WB_BASE,
        SHLD_S_WB_DEST
    } shld_state_t;

endpackage

// *** src/shld_unit.sv ***
// Contract
// RULE_01: Base field all ones selects the PC-relative literal form.
// RULE_02: Offsets zero-extend: 0..4095 for 12-bit form, 0..255 for 8-bit form.
// RULE_03: 8-bit form with index and writeback both clear is undefined.
// RULE_04: 8-bit form index=1, add=1, writeback=0 is the unprivileged halfword load.
// RULE_05: 8-bit form dest all ones, index=1, add=0, writeback=0 is a hint.
// RULE_06: Add bit set adds offset to base, clear subtracts it.
// RULE_07: Access at offset address when indexing, else at the plain base.
// RULE_08: Dest 13, dest 15 with writeback, or writeback with base==dest: unpredictable.
// RULE_09: Base writeback happens after the read, before the destination write.
// RULE_10: Halfword loads read two bytes and sign-extend to 32 bits.
// RULE_11: Literal base is the program counter aligned down to four.
// RULE_12: Literal offset is zero-extended 12 bits; U set adds, clear subtracts.
// RULE_13: Undefined hints are no-ops: no access, no register change.
// RULE_14: Register offset shifts left 0..3; short encoding always shifts zero.
// RULE_15: Register form always adds, uses the sum, never writes back.
// RULE_16: Register form with dest 13 or offset register 13/15 is unpredictable.
// RULE_17: Unprivileged loads access memory with unprivileged permission.
// RULE_18: Unprivileged loads: base plus 0..255, no writeback, dest 13/15 unpredictable.
// RULE_19: Unprivileged word load reads four bytes and writes them unchanged.
// RULE_20: Failed condition or faulted access leaves base and destination unchanged.
module shld_unit
    import shld_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Instruction issue from the pipeline
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic is32_i,
    input wire logic cond_pass_i,
    input wire logic [WIDTH-1:0] pc_i,
    input wire logic [WIDTH-1:0] base_val_i,
    input wire logic [WIDTH-1:0] off_val_i,
    output logic instr_ready_o,
    // Data memory port
    output logic mem_req_o,
    output logic [WIDTH-1:0] mem_addr_o,
    output logic [2:0] mem_size_o,
    output logic mem_unpriv_o,
    input wire logic mem_ack_i,
    input wire logic [WIDTH-1:0] mem_rdata_i,
    input wire logic mem_fault_i,
    // Register file write port
    output logic rf_we_o,
    output logic [3:0] rf_waddr_o,
    output logic [WIDTH-1:0] rf_wdata_o,
    // Completion status
    output logic done_o,
    output logic undef_o,
    output logic unpred_o,
    output logic fault_o,
    output logic hint_o
);
    // Sign extension of a loaded halfword, or the word untouched
    function automatic logic [WIDTH-1:0] shld_extend(input logic word, input logic [WIDTH-1:0] d);
        shld_extend = word ? d : {{(WIDTH - 16){d[15]}}, d[15:0]}; // RULE_10 RULE_19
    endfunction

    // Latched instruction and operands
    shld_state_t state;
    logic [31:0] instr_q;
    logic is32_q;
    logic cond_q;
    logic [WIDTH-1:0] pc_q;
    logic [WIDTH-1:0] base_q;
    logic [WIDTH-1:0] off_q;
    logic [WIDTH-1:0] rdata_q;

    // Decoder outputs
    shld_kind_t dec_kind;
    logic [3:0] dec_dest;
    logic [3:0] dec_base;
    logic [3:0] dec_offr;
    logic [1:0] dec_shift;
    logic [31:0] dec_imm32;
    logic dec_use_reg;
    logic dec_lit;
    logic dec_add;
    logic dec_index;
    logic dec_wback;
    logic dec_unpred;
    logic [WIDTH-1:0] agu_offset_addr;
    logic [WIDTH-1:0] agu_access_addr;

    // Next values
    shld_state_t next_state;
    logic next_ready;
    logic next_mem_req;
    logic [WIDTH-1:0] next_mem_addr;
    logic [2:0] next_mem_size;
    logic next_mem_unpriv;
    logic next_rf_we;
    logic [3:0] next_rf_waddr;
    logic [WIDTH-1:0] next_rf_wdata;
    logic next_done;
    logic next_undef;
    logic next_unpred;
    logic next_fault;
    logic next_hint;

    shld_decode u_decode (
        .instr_i(instr_q),
        .is32_i(is32_q),
        .kind_o(dec_kind),
        .dest_reg_field_o(dec_dest),
        .base_reg_field_o(dec_base),
        .offset_reg_field_o(dec_offr),
        .shift_2bit_o(dec_shift),
        .imm32_o(dec_imm32),
        .use_reg_o(dec_use_reg),
        .lit_o(dec_lit),
        .add_o(dec_add),
        .index_o(dec_index),
        .wback_o(dec_wback),
        .unpred_o(dec_unpred)
    );

    shld_agu #(
        .WIDTH(WIDTH),
        .ALIGN_BITS(SHLD_PC_ALIGN_BITS)
    ) u_agu (
        .base_val_i(base_q),
        .pc_i(pc_q),
        .off_val_i(off_q),
        .imm32_i(dec_imm32),
        .shift_i(dec_shift),
        .use_reg_i(dec_use_reg),
        .lit_i(dec_lit),
        .add_i(dec_add),
        .index_i(dec_index),
        .offset_addr_o(agu_offset_addr),
        .access_addr_o(agu_access_addr)
    );

    // Classification wires used by the sequencer
    wire is_load = dec_kind == SHLD_K_HALF || dec_kind == SHLD_K_HALF_UNPRIV ||
        dec_kind == SHLD_K_WORD_UNPRIV;
    wire is_word = dec_kind == SHLD_K_WORD_UNPRIV;
    wire is_unpriv = dec_kind == SHLD_K_HALF_UNPRIV || dec_kind == SHLD_K_WORD_UNPRIV;
    wire is_undef = dec_kind == SHLD_K_UNDEF || dec_kind == SHLD_K_NONE;
    wire take = instr_valid_i && instr_ready_o;
    wire ack_ok = mem_req_o && mem_ack_i && !mem_fault_i;
    wire ack_bad = mem_req_o && mem_ack_i && mem_fault_i;

    // Capture the issued instruction; operands are held for the whole sequence
    always_ff @(posedge clk_sys_i) begin
        if (take) begin
            instr_q <= instr_i;
            is32_q <= is32_i;
            cond_q <= cond_pass_i;
            pc_q <= pc_i;
            base_q <= base_val_i;
            off_q <= off_val_i;
        end
        if (ack_ok) begin
            rdata_q <= mem_rdata_i;
        end
    end

    // Sequencer; status outputs are one-cycle pulses, writes land one per cycle
    always_comb begin
        next_state = state;
        next_ready = instr_ready_o;
        next_mem_req = mem_req_o;
        next_mem_addr = mem_addr_o;
        next_mem_size = mem_size_o;
        next_mem_unpriv = mem_unpriv_o;
        next_rf_we = 1'b0;
        next_rf_waddr = rf_waddr_o;
        next_rf_wdata = rf_wdata_o;
        next_done = 1'b0;
        next_undef = 1'b0;
        next_unpred = 1'b0;
        next_fault = 1'b0;
        next_hint = 1'b0;
        case (state)
            SHLD_S_IDLE: begin
                if (take) begin
                    next_ready = 1'b0;
                    next_state = SHLD_S_EXEC;
                end
            end
            SHLD_S_EXEC: begin
                if (!cond_q || !is_load || dec_unpred) begin
                    // Nothing is touched when skipped, undefined, hinted or unpredictable
                    next_done = 1'b1; // RULE_20 RULE_13
                    next_undef = cond_q && is_undef; // RULE_03
                    next_hint = cond_q && dec_kind == SHLD_K_HINT; // RULE_05 RULE_13
                    next_unpred = cond_q && is_load && dec_unpred; // RULE_08 RULE_16 RULE_18
                    next_ready = 1'b1;
                    next_state = SHLD_S_IDLE;
                end else begin
                    next_mem_req = 1'b1;
                    next_mem_addr = agu_access_addr; // RULE_07
                    next_mem_size = is_word ? SHLD_SIZE_WORD : SHLD_SIZE_HALF; // RULE_10 RULE_19
                    next_mem_unpriv = is_unpriv; // RULE_17
                    next_state = SHLD_S_MEM;
                end
            end
            SHLD_S_MEM: begin
                if (ack_bad) begin
                    // A faulted read writes neither register
                    next_mem_req = 1'b0;
                    next_done = 1'b1;
                    next_fault = 1'b1; // RULE_20
                    next_ready = 1'b1;
                    next_state = SHLD_S_IDLE;
                end else if (ack_ok && dec_wback) begin
                    next_mem_req = 1'b0;
                    next_rf_we = 1'b1; // RULE_09
                    next_rf_waddr = dec_base;
                    next_rf_wdata = agu_offset_addr;
                    next_state = SHLD_S_WB_BASE;
                end else if (ack_ok) begin
                    next_mem_req = 1'b0;
                    next_rf_we = 1'b1;
                    next_rf_waddr = dec_dest;
                    next_rf_wdata = shld_extend(is_word, mem_rdata_i);
                    next_state = SHLD_S_WB_DEST;
                end
            end
            SHLD_S_WB_BASE: begin
                // Destination follows the base write by one cycle
                next_rf_we = 1'b1; // RULE_09
                next_rf_waddr = dec_dest;
                next_rf_wdata = shld_extend(is_word, rdata_q);
                next_state = SHLD_S_WB_DEST;
            end
            SHLD_S_WB_DEST: begin
                next_done = 1'b1;
                next_ready = 1'b1;
                next_state = SHLD_S_IDLE;
            end
            default: begin
                next_ready = 1'b1;
                next_mem_req = 1'b0;
                next_state = SHLD_S_IDLE;
            end
        endcase
    end

    // State and output registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= SHLD_S_IDLE;
            instr_ready_o <= 1'b1;
            mem_req_o <= 1'b0;
            mem_addr_o <= '0;
            mem_size_o <= SHLD_SIZE_HALF;
            mem_unpriv_o <= 1'b0;
            rf_we_o <= 1'b0;
            rf_waddr_o <= 4'h0;
            rf_wdata_o <= '0;
        end else begin
            state <= next_state;
            instr_ready_o <= next_ready;
            mem_req_o <= next_mem_req;
            mem_addr_o <= next_mem_addr;
            mem_size_o <= next_mem_size;
            mem_unpriv_o <= next_mem_unpriv;
            rf_we_o <= next_rf_we;
            rf_waddr_o <= next_rf_waddr;
            rf_wdata_o <= next_rf_wdata;
        end
    end

    // Completion pulses
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            done_o <= 1'b0;
            undef_o <= 1'b0;
            unpred_o <= 1'b0;
            fault_o <= 1'b0;
            hint_o <= 1'b0;
        end else begin
            done_o <= next_done;
            undef_o <= next_undef;
            unpred_o <= next_unpred;
            fault_o <= next_fault;
            hint_o <= next_hint;
        end
    end

    // Independent recompute of the expected access address for checking
    wire [WIDTH-1:0] chk_base = dec_lit ?
        {pc_q[WIDTH-1:SHLD_PC_ALIGN_BITS], {SHLD_PC_ALIGN_BITS{1'b0}}} : base_q;
    wire [WIDTH-1:0] chk_off = dec_use_reg ? (off_q << dec_shift) : dec_imm32;
    wire [WIDTH-1:0] chk_sum = dec_add ? chk_base + chk_off : chk_base - chk_off;
    wire exec_st = state == SHLD_S_EXEC;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    sequence s_read_ok;
        mem_req_o && mem_ack_i && !mem_fault_i;
    endsequence

    sequence s_base_then_dest;
        (rf_we_o && rf_waddr_o == dec_base && rf_wdata_o == chk_sum) ##1
            (rf_we_o && rf_waddr_o == dec_dest) ##1 done_o;
    endsequence

    sequence s_quiet2;
        (!mem_req_o && !rf_we_o) [*2];
    endsequence

    a_wb_order: assert property (s_read_ok and dec_wback |=> s_base_then_dest) // RULE_09
        else $error("base writeback not followed by destination write");

    a_addr_calc: assert property ($rose(mem_req_o) |-> // RULE_07
        mem_addr_o == (dec_index ? chk_sum : chk_base))
        else $error("access address does not match addressing mode");

    a_lit_offset: assert property ($rose(mem_req_o) && dec_lit |-> // RULE_11
        mem_addr_o[1:0] == dec_imm32[1:0] || !dec_add)
        else $error("literal base not word aligned");

    a_skip_cond: assert property (exec_st && !cond_q |=> done_o && !undef_o ##0 s_quiet2) // RULE_20
        else $error("failed condition changed state");

    a_fault_quiet: assert property (mem_req_o && mem_ack_i && mem_fault_i |=> // RULE_20
        fault_o && done_o && !rf_we_o ##1 !rf_we_o)
        else $error("faulted read wrote a register");

    a_hint_nop: assert property (exec_st && cond_q && dec_kind == SHLD_K_HINT |=> // RULE_13
        hint_o && done_o ##0 s_quiet2)
        else $error("hint did more than nothing");

    a_undef_flag: assert property (exec_st && cond_q && dec_kind == SHLD_K_UNDEF |=> // RULE_03
        undef_o && !mem_req_o)
        else $error("undefined encoding not flagged");

    a_unpred_flag: assert property (exec_st && cond_q && is_load && dec_unpred |=> // RULE_08
        unpred_o && !mem_req_o)
        else $error("unpredictable encoding executed");

    a_sext_half: assert property (state == SHLD_S_WB_DEST && !is_word |-> // RULE_10
        rf_wdata_o == {{(WIDTH - 16){rdata_q[15]}}, rdata_q[15:0]})
        else $error("halfword not sign extended");

    a_word_raw: assert property (state == SHLD_S_WB_DEST && is_word |-> // RULE_19
        rf_wdata_o == rdata_q && mem_size_o == SHLD_SIZE_WORD)
        else $error("word load altered data");

    a_unpriv_flag: assert property (mem_req_o |-> mem_unpriv_o == is_unpriv) // RULE_17
        else $error("privilege of access wrong");

    a_reg_no_wb: assert property ($rose(mem_req_o) && dec_use_reg |-> // RULE_15
        mem_addr_o == base_q + (off_q << dec_shift) && !dec_wback)
        else $error("register offset form misaddressed");

    a_req_hold: assert property (mem_req_o && !mem_ack_i |=> // RULE_07
        mem_req_o && $stable(mem_addr_o))
        else $error("request dropped before answer");
endmodule

// *** tb/shld_mem_model.sv ***
module shld_mem_model (
    // Clock and request side
    input wire logic clk_sys_i,
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [2:0] mem_size_i,
    input wire logic mem_unpriv_i,
    // Answer side
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o,
    output logic mem_fault_o,
    // Scenario controls and log
    input wire logic [31:0] cfg_data_i,
    input wire logic cfg_fault_i,
    input wire logic [3:0] cfg_delay_i,
    output logic [31:0] seen_addr_o,
    output logic [3:0] seen_info_o,
    output logic [7:0] seen_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    // Known start so the scrambled lines never settle to a lucky value
    initial begin
        {mem_ack_o, mem_fault_o, wait_cnt, seen_count_o} = '0;
        mem_rdata_o = 32'h5a5a_a5a5;
        seen_addr_o = '0;
        seen_info_o = '0;
    end
    // Answers off the falling edge; data lines flip every cycle outside an answer
    always @(negedge clk_sys_i) begin
        mem_rdata_o <= ~mem_rdata_o;
        mem_fault_o <= ~mem_fault_o;
        mem_ack_o <= 1'b0;
        if (mem_req_i && !mem_ack_o) begin
            if (wait_cnt == cfg_delay_i) begin
                mem_ack_o <= 1'b1;
                mem_rdata_o <= cfg_data_i;
                mem_fault_o <= cfg_fault_i;
                wait_cnt <= 4'h0;
                seen_addr_o <= mem_addr_i;
                seen_info_o <= {mem_unpriv_i, mem_size_i};
                seen_count_o <= seen_count_o + 8'h01;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// *** tb/tb.sv ***
module tb;
    import shld_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, srst_i = 1, instr_valid_i = 0, is32_i = 1, cond_pass_i = 1;
    logic [31:0] instr_i = 0, pc_i = 0, base_val_i = 0, off_val_i = 0, mem_rdata_i;
    logic mem_ack_i, mem_fault_i, instr_ready_o, mem_req_o, mem_unpriv_o, rf_we_o, done_o;
    logic undef_o, unpred_o, fault_o, hint_o, cfg_fault = 0;
    logic [31:0] mem_addr_o, rf_wdata_o, cfg_data = 0, seen_addr;
    logic [2:0] mem_size_o;
    logic [3:0] rf_waddr_o, cfg_delay = 0, seen_info, fl;
    logic [7:0] seen_count;
    logic [31:0] wa [2], wd [2], nwe, nreq;
    int fails = 0, checks_done = 0, cycles = 0;
    shld_unit dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .is32_i(is32_i), .cond_pass_i(cond_pass_i), .pc_i(pc_i),
        .base_val_i(base_val_i), .off_val_i(off_val_i), .instr_ready_o(instr_ready_o),
        .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
        .mem_unpriv_o(mem_unpriv_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
        .mem_fault_i(mem_fault_i), .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o),
        .rf_wdata_o(rf_wdata_o), .done_o(done_o), .undef_o(undef_o), .unpred_o(unpred_o),
        .fault_o(fault_o), .hint_o(hint_o));
    shld_mem_model mem_u (.clk_sys_i(clk_sys_i), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_size_i(mem_size_o), .mem_unpriv_i(mem_unpriv_o),
        .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .mem_fault_o(mem_fault_i),
        .cfg_data_i(cfg_data), .cfg_fault_i(cfg_fault), .cfg_delay_i(cfg_delay),
        .seen_addr_o(seen_addr), .seen_info_o(seen_info), .seen_count_o(seen_count));
    // 200 MHz clock
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard, far above the fewer than one hundred cycles the tests need
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Issue one instruction and log every register write until it completes
    task automatic run(input logic [31:0] ins, input logic [31:0] bv, input logic [31:0] rd,
        input logic w32 = 1, input logic cnd = 1, input logic [31:0] pc = 0,
        input logic [31:0] ov = 0, input logic flt = 0, input logic [3:0] dly = 0);
        logic [7:0] c0;
        c0 = seen_count;
        {instr_i, base_val_i, is32_i, cond_pass_i, pc_i, off_val_i} = {ins, bv, w32, cnd, pc, ov};
        {cfg_data, cfg_fault, cfg_delay} = {rd, flt, dly};
        instr_valid_i = 1;
        @(negedge clk_sys_i);
        instr_valid_i = 0;
        nwe = 0;
        while (done_o !== 1'b1) begin
            if (rf_we_o === 1'b1 && nwe < 2) begin
                wa[nwe] = {28'h0, rf_waddr_o};
                wd[nwe] = rf_wdata_o;
                nwe++;
            end
            @(negedge clk_sys_i);
        end
        fl = {undef_o, unpred_o, fault_o, hint_o};
        nreq = {24'h0, seen_count - c0};
    endtask
    task automatic chk_ld(input logic [31:0] a, input logic [3:0] inf, input logic [31:0] nw,
        input logic [3:0] dst, input logic [31:0] d);
        chk(nreq, 1);
        chk(seen_addr, a);
        chk({28'h0, seen_info}, {28'h0, inf});
        chk(nwe, nw);
        chk(wa[nw-1], {28'h0, dst});
        chk(wd[nw-1], d);
        chk({28'h0, fl}, 0);
    endtask
    task automatic chk_nop(input logic [3:0] f);
        chk(nreq, 0);
        chk(nwe, 0);
        chk({28'h0, fl}, {28'h0, f});
    endtask
    task automatic t_offset_12bit();
        run({SHLD_OP_OFFSET_12BIT, 4'h1, 4'h2, 12'hfff}, 32'h1000, 32'h0000_8001);
        chk_ld(32'h1fff, 4'h2, 1, 4'h2, 32'hffff_8001);
        $display("test offset_12bit finished");
    endtask
    task automatic t_index8();
        run({SHLD_OP_GRP93, 4'h3, 4'h4, 4'hd, 8'hff}, 32'h2000, 32'h7fff, 1, 1, 0, 0, 0, 3);
        chk_ld(32'h1f01, 4'h2, 2, 4'h4, 32'h0000_7fff);
        chk(wa[0], 3);
        chk(wd[0], 32'h1f01);
        run({SHLD_OP_GRP93, 4'h3, 4'h5, 4'hb, 8'h10}, 32'h3000, 32'h5a5a_ffff);
        chk_ld(32'h3000, 4'h2, 2, 4'h5, 32'hffff_ffff);
        chk(wd[0], 32'h3010);
        $display("test index8 finished");
    endtask
    task automatic t_undef_hint();
        run({SHLD_OP_GRP93, 4'h3, 4'h4, 4'ha, 8'h01}, 32'h2000, 0);
        chk_nop(4'h8);
        run({SHLD_OP_GRP93, 4'h3, 4'hf, 4'hc, 8'h01}, 32'h2000, 0);
        chk_nop(4'h1);
        run({SHLD_OP_OFFSET_12BIT, 4'h3, 4'hf, 12'h001}, 32'h2000, 0);
        chk_nop(4'h1);
        run({SHLD_OP_WORD_UNPRIV, 4'hf, 4'h8, SHLD_UNPRIV_SEL, 8'h04}, 32'h0, 0);
        chk_nop(4'h8);
        $display("test undef_hint finished");
    endtask
    task automatic t_unpriv();
        run({SHLD_OP_GRP93, 4'h6, 4'h7, 4'he, 8'hff}, 32'h4000, 32'h0000_1234);
        chk_ld(32'h40ff, 4'ha, 1, 4'h7, 32'h0000_1234);
        run({SHLD_OP_WORD_UNPRIV, 4'h6, 4'h8, SHLD_UNPRIV_SEL, 8'h04}, 32'h4000, 32'h89ab_cdef);
        chk_ld(32'h4004, 4'hc, 1, 4'h8, 32'h89ab_cdef);
        $display("test unpriv finished");
    endtask
    task automatic t_unpred();
        logic [31:0] tbl [6] = '{{SHLD_OP_OFFSET_12BIT, 8'h1d, 12'h0}, {SHLD_OP_GRP93, 8'h1f, 12'hf00},
            {SHLD_OP_GRP93, 8'h55, 12'hd00}, {SHLD_OP_GRP93, 8'h1f, 12'he00},
            {SHLD_OP_WORD_UNPRIV, 8'h1d, 12'he00}, {SHLD_OP_GRP93, 8'h12, 12'h00f}};
        for (int i = 0; i < 6; i++) begin
            run(tbl[i], 32'h100, 0);
            chk_nop(4'h4);
        end
        $display("test unpred finished");
    endtask
    task automatic t_literal();
        run({SHLD_OP_LIT_HI, 1'b0, SHLD_OP_LIT_LO, 4'h9, 12'h004}, 32'h9, 32'h80, 1, 1, 32'h1006);
        chk_ld(32'h1000, 4'h2, 1, 4'h9, 32'h80);
        run({SHLD_OP_LIT_HI, 1'b1, SHLD_OP_LIT_LO, 4'h9, 12'hfff}, 32'h9, 32'h80, 1, 1, 32'h2003);
        chk_ld(32'h2fff, 4'h2, 1, 4'h9, 32'h80);
        $display("test literal finished");
    endtask
    task automatic t_regoff();
        run({SHLD_OP_GRP93, 8'h12, SHLD_REGW_ZERO, 2'h3, 4'h4}, 32'h100, 32'h1, 1, 1, 0, 32'h11);
        chk_ld(32'h188, 4'h2, 1, 4'h2, 32'h1);
        run({16'h0, SHLD_OP_REG16, 3'h1, 3'h2, 3'h3}, 32'h200, 32'h2, 0, 1, 0, 32'h7);
        chk_ld(32'h207, 4'h2, 1, 4'h3, 32'h2);
        $display("test regoff finished");
    endtask
    task automatic t_cond_fault();
        run({SHLD_OP_OFFSET_12BIT, 4'h1, 4'h2, 12'h010}, 32'h1000, 32'h1, 1, 0);
        chk_nop(4'h0);
        run({SHLD_OP_OFFSET_12BIT, 4'h1, 4'h2, 12'h010}, 32'h1000, 32'h1, 1, 1, 0, 0, 1, 2);
        chk(nreq, 1);
        chk(nwe, 0);
        chk({28'h0, fl}, 32'h2);
        $display("test cond_fault finished");
    endtask
    // Reset, then the scenarios back to back
    initial begin
        repeat (5) @(negedge clk_sys_i);
        srst_i = 0;
        chk({31'h0, instr_ready_o}, 1);
        t_offset_12bit();
        t_index8();
        t_undef_hint();
        t_unpriv();
        t_unpred();
        t_literal();
        t_regoff();
        t_cond_fault();
        tally_and_finish();
    end
endmodule
